// ===== rts_pkg.sv
// Constants, field layouts and types of the reset and time-out sequencer.
// Assumes a 125 MHz bus clock and single-word AHB-Lite register access.
package rts_pkg;

  // Bus clock.
  localparam int CLK_PERIOD_NS = 8;

  // Power-up timer: 72 ms counted on the 31.25 kHz internal RC oscillator.
  localparam int POWERUP_TIMER_TIME_MS  = 72;
  localparam int RC_FREQ_HZ    = 31250;
  localparam int POWERUP_TIMER_RC_TICKS = POWERUP_TIMER_TIME_MS * RC_FREQ_HZ / 1000;
  localparam int POWERUP_TIMER_W        = 12;

  // Oscillator start-up timer on the primary oscillator input.
  localparam int OST_CYCLES = 1024;
  localparam int OST_W      = 11;

  // CPU start-up delay, least figure of 5-10 us, rounded up.
  localparam int CPU_START_NS     = 5000;
  localparam int CPU_START_CYCLES = (CPU_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_W          = 10;

  // Brown-out persistence of about 100 us before a reset is taken.
  localparam int BOR_MIN_US       = 100;
  localparam int BOR_CYCLES_DEF   = BOR_MIN_US * 1000 / CLK_PERIOD_NS;

  // Glitch filter on the external reset pin, rounded up.
  localparam int PIN_FILTER_NS     = 100;
  localparam int PIN_FILTER_CYCLES = (PIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PIN_W             = 4;

  // Register byte offsets.
  localparam logic [7:0] OFF_POWER_CONTROL_STATUS   = 8'h00;
  localparam logic [7:0] OFF_CONFIG = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;

  // Power control bits.
  localparam int POWER_CONTROL_STATUS_BROWNOUT_BIT = 0;
  localparam int POWER_CONTROL_STATUS_POWERON_BIT  = 1;
  localparam logic [1:0] POWER_CONTROL_STATUS_RST  = 2'h0;

  // Status register field positions.
  localparam int STAT_PD_BIT    = 0;
  localparam int STAT_TO_BIT    = 1;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_HOLD_BIT  = 8;

  // Oscillator selection codes that need the start-up count.
  localparam logic [2:0] OSC_LP = 3'h0;
  localparam logic [2:0] OSC_XT = 3'h1;
  localparam logic [2:0] OSC_HS = 3'h2;

  typedef struct packed {
    logic       reset_pin_select;
    logic       brownout_enable;
    logic       powerup_timer_enable_n;
    logic [2:0] osc_select_field;
  } cfg_t;

  // Erased configuration: reset pin, brown-out on, power-up timer off, external RC.
  localparam cfg_t CFG_RST = 6'h3F;

  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
  } flags_t;

  typedef enum logic [2:0] {
    S_RUN      = 3'b000,
    S_START    = 3'b001,
    S_BOR_HOLD = 3'b010,
    S_POWERUP_TIMER     = 3'b011,
    S_OST      = 3'b100,
    S_WAIT     = 3'b101
  } seq_state_t;

endpackage

// ===== reset_timeout_sequencer.sv
// Reset source merging, time-out sequencing and reset-cause flags.
// Assumes asynchronous supply, pin and oscillator inputs and a same-clock CPU core.
`timescale 1ns/10ps
`default_nettype none

// Operation
// [RULE1] Resets clear registers; watchdog wake-up keeps them
// [RULE2] Reset-independent registers receive no reset line
// [RULE3] CPU start-up delay after power-on, brown-out, wake
// [RULE4] Reset pin glitches are filtered out
// [RULE5] Watchdog reset never drives the pin
// [RULE6] Configuration selects pin as reset or GPIO
// [RULE7] Power-up timer on RC oscillator holds reset
// [RULE8] Active-low enable turns power-up timer on
// [RULE9] Start-up count of 1024 follows power-up timer
// [RULE10] Start-up count only crystal modes, power-on, wake
// [RULE11] Brown-out resets after low supply persists
// [RULE12] Brown-out holds, then restarts on new dips
// [RULE13] Brown-out and power-up enables are independent
// [RULE14] Sequence: power-up delay, start-up count, release
// [RULE15] Pin held past delays releases immediately
// [RULE16] Power bit 0 cleared by brown-out reset
// [RULE17] Power bit 1 cleared by power-on only
// [RULE18] Non-crystal modes: power-up delay or CPU delay
// [RULE19] Time-out and power-down flags follow reset cause
// [RULE20] Resets load address zero; wake resumes next
// [RULE21] GPIO mode treats reset input as deasserted
// [RULE22] Crystal codes are 010, 001 and 000
// [RULE23] Supply indications are synchronised before use
module reset_timeout_sequencer
  #(parameter int unsigned BOR_CYCLES = rts_pkg::BOR_CYCLES_DEF)
  (
  input  wire logic        hclk,            // Bus clock.
  input  wire logic        hresetn,         // Asynchronous reset, active low.
  input  wire logic        hsel,            // Slave select.
  input  wire logic [31:0] haddr,           // Byte address.
  input  wire logic [1:0]  htrans,          // Transfer type.
  input  wire logic        hwrite,          // Write when high.
  input  wire logic [2:0]  hsize,           // Transfer size, word only.
  input  wire logic [31:0] hwdata,          // Write data.
  input  wire logic        hready,          // Bus ready.
  output var  logic        hreadyout,       // Slave ready.
  output var  logic        hresp,           // Response, always OKAY.
  output var  logic [31:0] hrdata,          // Read data.
  input  wire logic        ext_reset_pin_n, // Shared reset pin, active low.
  input  wire logic        supply_rise,     // Supply rise detected.
  input  wire logic        low_supply,      // Supply below brown-out threshold.
  input  wire logic        rc_osc_in,       // Internal RC oscillator.
  input  wire logic        primary_osc_in,  // Primary oscillator input.
  input  wire logic        watchdog,        // Watchdog time-out pulse.
  input  wire logic        cpu_sleeping,    // CPU is asleep.
  input  wire logic        sleep_enter,     // CPU enters sleep, pulse.
  input  wire logic        wake_irq,        // Interrupt wake-up request.
  output var  logic        chip_hold,       // CPU held off.
  output var  logic        regs_reset,      // Reset of resettable registers.
  output var  logic        pc_load_zero,    // Start at address zero, pulse.
  output var  logic        pc_resume_next,  // Resume at next address, pulse.
  output var  logic        reset_pin_oe_n   // Reset pin output enable, active low.
  );
  import rts_pkg::*;

  localparam int BOR_W = $clog2(BOR_CYCLES + 1);
  localparam logic [BOR_W-1:0]   BOR_LAST   = BOR_W'(BOR_CYCLES - 1);
  localparam logic [BOR_W-1:0]   BOR_SAT    = BOR_W'(BOR_CYCLES);
  localparam logic [POWERUP_TIMER_W-1:0]  POWERUP_TIMER_LOAD  = POWERUP_TIMER_W'(POWERUP_TIMER_RC_TICKS);
  localparam logic [OST_W-1:0]   OST_LOAD   = OST_W'(OST_CYCLES);
  localparam logic [START_W-1:0] START_LOAD = START_W'(CPU_START_CYCLES);
  localparam logic [PIN_W-1:0]   PIN_LAST   = PIN_W'(PIN_FILTER_CYCLES - 1);
  localparam logic [4:0]         SYNC_RST   = 5'h10;

  // Synchroniser order: pin, supply rise, low supply, RC, primary oscillator.
  logic [4:0]         meta_q;
  logic [4:0]         sync_q;
  logic [4:0]         prev_q;
  seq_state_t         st_q,       st_d;
  cfg_t               cfg_q,      cfg_d;
  flags_t             flags_q,    flags_d;
  logic [1:0]         power_control_status_q,     power_control_status_d;
  logic [POWERUP_TIMER_W-1:0]  powerup_timer_q,     powerup_timer_d;
  logic [OST_W-1:0]   ost_q,      ost_d;
  logic [START_W-1:0] start_q,    start_d;
  logic [BOR_W-1:0]   bor_cnt_q,  bor_cnt_d;
  logic [PIN_W-1:0]   flt_q,      flt_d;
  logic               pin_act_q,  pin_act_d;
  logic               wake_q,     wake_d;
  logic               ostreq_q,   ostreq_d;
  logic               wr_q,       wr_d;
  logic [7:0]         addr_q,     addr_d;
  logic [31:0]        rdata_q,    rdata_d;
  logic               hold_q,     hold_d;
  logic               rreset_q,   rreset_d;
  logic               zero_q,     zero_d;
  logic               resume_q,   resume_d;
  logic               pin_s;
  logic               low_s;
  logic               ev_por;
  logic               ev_bor;
  logic               rc_tick;
  logic               osc_tick;
  logic               crystal;
  logic               pin_raw;
  logic               accept;

  assign pin_s    = sync_q[4];
  assign low_s    = sync_q[2];                                             // RULE23
  assign ev_por   = sync_q[3] && !prev_q[3];                               // RULE23
  assign rc_tick  = sync_q[1] && !prev_q[1];                               // RULE7
  assign osc_tick = sync_q[0] && !prev_q[0];                               // RULE9
  assign crystal  = (cfg_q.osc_select_field == OSC_LP) ||
                    (cfg_q.osc_select_field == OSC_XT) ||
                    (cfg_q.osc_select_field == OSC_HS);                    // RULE22
  assign pin_raw  = cfg_q.reset_pin_select && !pin_s;                      // RULE6
  assign ev_bor   = cfg_q.brownout_enable && low_s && (bor_cnt_q == BOR_LAST); // RULE11
  assign accept   = hsel && htrans[1] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= SYNC_RST;
      sync_q <= SYNC_RST;
      prev_q <= SYNC_RST;
    end else begin
      meta_q <= {ext_reset_pin_n, supply_rise, low_supply, rc_osc_in, primary_osc_in};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  always_comb begin
    st_d      = st_q;
    cfg_d     = cfg_q;
    flags_d   = flags_q;
    power_control_status_d    = power_control_status_q;
    powerup_timer_d    = powerup_timer_q;
    ost_d     = ost_q;
    start_d   = start_q;
    bor_cnt_d = bor_cnt_q;
    flt_d     = flt_q;
    pin_act_d = pin_act_q;
    wake_d    = wake_q;
    ostreq_d  = ostreq_q;
    zero_d    = 1'b0;
    resume_d  = 1'b0;
    wr_d      = accept && hwrite;
    addr_d    = accept ? haddr[7:0] : addr_q;
    rdata_d   = rdata_q;
    if (accept && !hwrite) begin
      rdata_d = 32'h0000_0000;
      case (haddr[7:0])
        OFF_POWER_CONTROL_STATUS:   rdata_d[1:0] = power_control_status_q;
        OFF_CONFIG: rdata_d[5:0] = cfg_q;
        OFF_STATUS: begin
          rdata_d[STAT_PD_BIT]                    = flags_q.powerdown_flag;
          rdata_d[STAT_TO_BIT]                    = flags_q.timeout_flag;
          rdata_d[STAT_STATE_LSB +: 3]            = st_q;
          rdata_d[STAT_HOLD_BIT]                  = hold_q;
        end
        default:    rdata_d = 32'h0000_0000;
      endcase
    end
    // Software writes land first so that hardware events below win.
    if (wr_q && (addr_q == OFF_POWER_CONTROL_STATUS)) begin
      power_control_status_d = hwdata[1:0];                                                // RULE16
    end
    if (wr_q && (addr_q == OFF_CONFIG)) begin
      cfg_d = cfg_t'(hwdata[5:0]);
    end
    if (sleep_enter) begin
      flags_d.timeout_flag   = 1'b1;
      flags_d.powerdown_flag = 1'b0;
    end
    if (start_q != '0) begin
      start_d = START_W'(start_q - 1'b1);                                  // RULE3
    end
    if (cfg_q.brownout_enable && low_s) begin                              // RULE13
      if (bor_cnt_q != BOR_SAT) begin
        bor_cnt_d = BOR_W'(bor_cnt_q + 1'b1);                              // RULE11
      end
    end else begin
      bor_cnt_d = '0;
    end
    if (!cfg_q.reset_pin_select) begin
      pin_act_d = 1'b0;                                                    // RULE21
      flt_d     = '0;
    end else if (pin_raw != pin_act_q) begin
      if (flt_q == PIN_LAST) begin
        pin_act_d = pin_raw;                                               // RULE4
        flt_d     = '0;
      end else begin
        flt_d = PIN_W'(flt_q + 1'b1);
      end
    end else begin
      flt_d = '0;
    end
    case (st_q)
      S_START: begin
        if (!cfg_q.powerup_timer_enable_n) begin                           // RULE8
          st_d   = S_POWERUP_TIMER;
          powerup_timer_d = POWERUP_TIMER_LOAD;
        end else if (ostreq_q && crystal) begin                            // RULE10
          st_d  = S_OST;
          ost_d = OST_LOAD;
        end else begin
          st_d = S_WAIT;                                                   // RULE18
        end
      end
      S_BOR_HOLD: begin
        if (!low_s) begin
          st_d = S_START;                                                  // RULE12
        end
      end
      S_POWERUP_TIMER: begin
        if (cfg_q.brownout_enable && low_s) begin
          st_d = S_BOR_HOLD;                                               // RULE12
        end else if (powerup_timer_q == '0) begin
          if (ostreq_q && crystal) begin                                   // RULE14
            st_d  = S_OST;
            ost_d = OST_LOAD;                                              // RULE9
          end else begin
            st_d = S_WAIT;
          end
        end else if (rc_tick) begin
          powerup_timer_d = POWERUP_TIMER_W'(powerup_timer_q - 1'b1);                                 // RULE7
        end
      end
      S_OST: begin
        if (ost_q == '0) begin
          st_d = S_WAIT;
        end else if (osc_tick) begin
          ost_d = OST_W'(ost_q - 1'b1);                                    // RULE9
        end
      end
      S_WAIT: begin
        if ((start_q == '0) && !pin_act_q) begin                           // RULE15
          st_d     = S_RUN;
          resume_d = wake_q;                                               // RULE20
          zero_d   = !wake_q;                                              // RULE20
        end
      end
      S_RUN: begin
        st_d = S_RUN;
      end
      default: st_d = S_START;
    endcase
    if (ev_por) begin
      st_d     = S_START;
      wake_d   = 1'b0;
      ostreq_d = 1'b1;
      start_d  = START_LOAD;                                               // RULE3
      flags_d  = '{timeout_flag: 1'b1, powerdown_flag: 1'b1};              // RULE19
      power_control_status_d[POWER_CONTROL_STATUS_POWERON_BIT] = 1'b0;                                     // RULE17
    end else if (ev_bor) begin
      st_d     = S_BOR_HOLD;                                               // RULE12
      wake_d   = 1'b0;
      ostreq_d = 1'b0;
      start_d  = START_LOAD;
      flags_d  = '{timeout_flag: 1'b1, powerdown_flag: 1'b1};
      power_control_status_d[POWER_CONTROL_STATUS_BROWNOUT_BIT] = 1'b0;                                    // RULE16
    end else if (st_q == S_RUN) begin
      if (cpu_sleeping && (watchdog || wake_irq)) begin
        st_d     = crystal ? S_OST : S_WAIT;                               // RULE10
        ost_d    = OST_LOAD;
        wake_d   = 1'b1;                                                   // RULE1
        ostreq_d = 1'b1;
        start_d  = START_LOAD;
        flags_d  = '{timeout_flag: wake_irq && !watchdog, powerdown_flag: 1'b0}; // RULE19
      end else if (pin_act_q) begin
        st_d   = S_WAIT;
        wake_d = 1'b0;
        if (cpu_sleeping) begin
          flags_d = '{timeout_flag: 1'b1, powerdown_flag: 1'b0};           // RULE19
        end
      end else if (watchdog) begin
        st_d                 = S_WAIT;                                     // RULE5
        wake_d               = 1'b0;
        flags_d.timeout_flag = 1'b0;                                       // RULE19
      end
    end else if (pin_act_q) begin
      wake_d = 1'b0;                                                       // RULE1
    end
    hold_d   = (st_d != S_RUN);
    rreset_d = (st_d != S_RUN) && !wake_d;                                 // RULE2
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q      <= S_START;
      cfg_q     <= CFG_RST;
      flags_q   <= '{timeout_flag: 1'b1, powerdown_flag: 1'b1};
      power_control_status_q    <= POWER_CONTROL_STATUS_RST;
      powerup_timer_q    <= '0;
      ost_q     <= '0;
      start_q   <= START_LOAD;
      bor_cnt_q <= '0;
      flt_q     <= '0;
      pin_act_q <= 1'b0;
      wake_q    <= 1'b0;
      ostreq_q  <= 1'b1;
      wr_q      <= 1'b0;
      addr_q    <= 8'h00;
      rdata_q   <= 32'h0000_0000;
      hold_q    <= 1'b1;
      rreset_q  <= 1'b1;
      zero_q    <= 1'b0;
      resume_q  <= 1'b0;
    end else begin
      st_q      <= st_d;
      cfg_q     <= cfg_d;
      flags_q   <= flags_d;
      power_control_status_q    <= power_control_status_d;
      powerup_timer_q    <= powerup_timer_d;
      ost_q     <= ost_d;
      start_q   <= start_d;
      bor_cnt_q <= bor_cnt_d;
      flt_q     <= flt_d;
      pin_act_q <= pin_act_d;
      wake_q    <= wake_d;
      ostreq_q  <= ostreq_d;
      wr_q      <= wr_d;
      addr_q    <= addr_d;
      rdata_q   <= rdata_d;
      hold_q    <= hold_d;
      rreset_q  <= rreset_d;
      zero_q    <= zero_d;
      resume_q  <= resume_d;
    end
  end

  // The slave always answers at once, so ready and response are constants after reset.
  logic ready_q;
  logic resp_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_q <= 1'b1;
      resp_q  <= 1'b0;
    end else begin
      ready_q <= 1'b1;
      resp_q  <= 1'b0;
    end
  end

  assign hreadyout      = ready_q;
  assign hresp          = resp_q;
  assign hrdata         = rdata_q;
  assign chip_hold      = hold_q;
  assign regs_reset     = rreset_q;
  assign pc_load_zero   = zero_q;
  assign pc_resume_next = resume_q;
  assign reset_pin_oe_n = ready_q;                                         // RULE5

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_WAKE_KEEPS: assert property (st_q == S_RUN && cpu_sleeping && watchdog && !ev_por // RULE1
    && !ev_bor |=> !regs_reset && chip_hold) else $error("wake reset registers");
  AST_START_DELAY: assert property (st_q == S_RUN |-> start_q == '0) // RULE3
    else $error("released during CPU start-up");
  AST_PIN_FILTER: assert property ($rose(pin_act_q) |-> $past(flt_q) == PIN_LAST) // RULE4
    else $error("pin reset without filter");
  AST_PIN_NEVER: assert property (reset_pin_oe_n) // RULE5
    else $error("reset pin driven");
  AST_GPIO_MODE: assert property (!cfg_q.reset_pin_select |=> !pin_act_q) // RULE21
    else $error("GPIO pin resets chip");
  AST_POWERUP_TIMER_HOLD: assert property (st_q == S_POWERUP_TIMER |-> chip_hold ##0 rreset_q) // RULE7
    else $error("released while power-up timer runs");
  AST_POWERUP_TIMER_EN: assert property (st_q == S_START && !ev_por && !ev_bor // RULE8
    |=> (st_q == S_POWERUP_TIMER) == $past(!cfg_q.powerup_timer_enable_n))
    else $error("power-up timer enable wrong");
  AST_OST_ORDER: assert property (st_q == S_POWERUP_TIMER ##1 st_q == S_OST // RULE9
    |-> $past(powerup_timer_q) == '0) else $error("start-up count before power-up delay");
  AST_OST_MODE: assert property ($rose(st_q == S_OST) // RULE10
    |-> $past(crystal) && ($past(ostreq_q) || $past(st_q) == S_RUN))
    else $error("start-up count in wrong mode");
  AST_BOR_HOLD: assert property (st_q == S_BOR_HOLD && low_s && !ev_por // RULE12
    |=> st_q == S_BOR_HOLD) else $error("brown-out hold left early");
  AST_POR_FLAGS: assert property (ev_por // RULE19
    |=> flags_q.timeout_flag && flags_q.powerdown_flag && !power_control_status_q[POWER_CONTROL_STATUS_POWERON_BIT])
    else $error("power-on flags wrong");
  AST_BOR_BIT: assert property (ev_bor && !ev_por |=> !power_control_status_q[POWER_CONTROL_STATUS_BROWNOUT_BIT]) // RULE16
    else $error("brown-out bit not cleared");
  AST_PC_ONE: assert property (pc_resume_next |-> !pc_load_zero ##1 !pc_resume_next) // RULE20
    else $error("both program counter loads");

  COV_POWERUP_TIMER_OST: cover property (st_q == S_POWERUP_TIMER ##1 st_q == S_OST);
  COV_WAKE:     cover property (pc_resume_next);
  COV_BOR_AGAIN: cover property (st_q == S_POWERUP_TIMER ##1 st_q == S_BOR_HOLD);
  COV_PIN_RST:  cover property (st_q == S_RUN && pin_act_q ##1 st_q == S_WAIT);

endmodule

`default_nettype wire

// ===== cpu_model.sv
// Behavioural CPU core on the far side of the sequencer.
// Assumes chip_hold and the start pulses come from the sequencer on hclk.
`timescale 1ns/10ps
`default_nettype none
module cpu_model (
  input  wire logic        hclk,           // Clock.
  input  wire logic        hresetn,        // Asynchronous reset, active low.
  input  wire logic        chip_hold,      // CPU held off.
  input  wire logic        pc_load_zero,   // Start at zero.
  input  wire logic        pc_resume_next, // Resume at next address.
  input  wire logic        sleep_req,      // Bench asks the CPU to sleep.
  output var  logic        cpu_sleeping,   // CPU asleep.
  output var  logic        sleep_enter,    // Sleep entry pulse.
  output var  logic [12:0] pc,             // Program counter.
  output var  logic [12:0] start_pc        // Address of the last start.
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_sleeping <= 1'b0;
      sleep_enter  <= 1'b0;
      pc           <= 13'h0;
      start_pc     <= 13'h0;
    end else begin
      sleep_enter <= sleep_req && !chip_hold && !cpu_sleeping;
      if (sleep_req && !chip_hold) begin
        cpu_sleeping <= 1'b1;
      end
      if (pc_load_zero) begin
        pc           <= 13'h0;
        start_pc     <= 13'h0;
        cpu_sleeping <= 1'b0;
      end else if (pc_resume_next) begin
        pc           <= pc + 13'h1;
        start_pc     <= pc + 13'h1;
        cpu_sleeping <= 1'b0;
      end else if (!chip_hold && !cpu_sleeping) begin
        pc <= pc + 13'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== reset_timeout_sequencer_bench.sv
// Self-checking testbench of the reset and time-out sequencer.
// Assumes cpu_model on the far side and the register map of rts_pkg.
`timescale 1ns/10ps
`default_nettype none
module reset_timeout_sequencer_bench;
  import rts_pkg::*;
  localparam int BORC = 20;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0]  htrans = 0;
  logic        pin_n = 1, supply_rise = 0, low_supply = 0, rc = 0, osc = 0;
  logic        wdog = 0, wake = 0, sleep_req = 0, cpu_sleeping, sleep_enter;
  logic        chip_hold, regs_reset, pc_load_zero, pc_resume_next, oe_n;
  logic [12:0] pc, start_pc, exp_pc;
  int          mismatches = 0, check_count = 0, seed = 46, n, rr, exp_to, exp_pd, exp_power_control_status;

  reset_timeout_sequencer #(.BOR_CYCLES(BORC)) i_dut (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .ext_reset_pin_n(pin_n), .supply_rise(supply_rise),
    .low_supply(low_supply), .rc_osc_in(rc), .primary_osc_in(osc), .watchdog(wdog),
    .cpu_sleeping(cpu_sleeping), .sleep_enter(sleep_enter), .wake_irq(wake),
    .chip_hold(chip_hold), .regs_reset(regs_reset), .pc_load_zero(pc_load_zero),
    .pc_resume_next(pc_resume_next), .reset_pin_oe_n(oe_n));
  cpu_model i_cpu (.hclk(hclk), .hresetn(hresetn), .chip_hold(chip_hold),
    .pc_load_zero(pc_load_zero), .pc_resume_next(pc_resume_next), .sleep_req(sleep_req),
    .cpu_sleeping(cpu_sleeping), .sleep_enter(sleep_enter), .pc(pc), .start_pc(start_pc));

  initial forever #4 hclk = ~hclk;
  // Oscillators of roughly 8 and 4 bus cycles, unrelated in phase to hclk.
  initial forever #32.3 rc = ~rc;
  initial forever #16.3 osc = ~osc;

  task stop_test;
    if (mismatches == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk_in(input int v, input int lo, input int hi);
    check_count++;
    if (v < lo || v > hi) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
    end
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Drives one event source for len cycles: 0 watchdog, 1 wake, 2 sleep, 3 pin, 4 dip, 5 rise.
  task ev(input int k, input int len);
    @(posedge hclk);
    case (k)
      0: wdog <= 1'b1;
      1: wake <= 1'b1;
      2: sleep_req <= 1'b1;
      3: pin_n <= 1'b0;
      4: low_supply <= 1'b1;
      default: supply_rise <= 1'b1;
    endcase
    repeat (len) @(posedge hclk);
    wdog <= 1'b0;
    wake <= 1'b0;
    sleep_req <= 1'b0;
    pin_n <= 1'b1;
    low_supply <= 1'b0;
    supply_rise <= 1'b0;
  endtask
  // Counts the held cycles; n stays 0 when the hold never starts within 60 cycles.
  task hold;
    n = 0;
    rr = 0;
    repeat (60) if (chip_hold !== 1'b1) @(posedge hclk);
    while (chip_hold === 1'b1 && n < 30000) begin
      rr = rr | ((regs_reset === 1'b1) ? 1 : (regs_reset === 1'b0) ? 0 : 2);
      @(posedge hclk);
      n++;
    end
    repeat (2) @(posedge hclk);
  endtask
  task regs(input logic [31:0] m);
    bus(1'b0, OFF_STATUS, 32'h0);
    chk(rd & 32'h173, {exp_to[0], exp_pd[0]});
    bus(1'b0, OFF_POWER_CONTROL_STATUS, 32'h0);
    chk(rd & m, exp_power_control_status & m);
    chk({hresp, oe_n}, 2'b01);
  endtask
  task set_power_control_status;
    bus(1'b1, OFF_POWER_CONTROL_STATUS, $random(seed) | 3);
    exp_power_control_status = 3;
  endtask

  initial begin
    repeat (90000) @(posedge hclk);
    mismatches++;
    stop_test;
  end

  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    exp_to = 1; exp_pd = 1; exp_power_control_status = 0;
    hold;
    chk_in(n, CPU_START_CYCLES - 2, CPU_START_CYCLES + 40);
    chk(start_pc, 13'h0);
    bus(1'b0, OFF_CONFIG, 32'h0);
    chk(rd, 32'h3F);
    regs(32'hFFFFFFFF);
    set_power_control_status;
    ev(3, 1 + $unsigned($random(seed)) % 8);
    hold;
    chk_in(n, 0, 0);
    ev(3, 800);
    chk(chip_hold, 1'b1);
    hold;
    chk_in(n, 1, 30);
    chk_in(rr, 1, 1);
    chk(start_pc, 13'h0);
    regs(32'hFFFFFFFF);
    ev(0, 1);
    exp_to = 0;
    hold;
    chk_in(rr, 1, 1);
    chk(start_pc, 13'h0);
    regs(32'hFFFFFFFF);
    ev(4, 2 + $unsigned($random(seed)) % (BORC - 4));
    hold;
    chk_in(n, 0, 0);
    ev(4, BORC + 20);
    exp_to = 1; exp_pd = 1; exp_power_control_status = 2;
    hold;
    // The start-up delay began at the brown-out event, inside the dip.
    chk_in(n, CPU_START_CYCLES - 24, 2000);
    chk_in(rr, 1, 1);
    regs(32'hFFFFFFFF);
    set_power_control_status;
    bus(1'b1, OFF_CONFIG, 32'h37);
    ev(4, BORC + 20);
    exp_power_control_status = 2;
    repeat (3000) @(posedge hclk);
    chk(chip_hold, 1'b1);
    ev(4, BORC + 20);
    hold;
    chk_in(n, POWERUP_TIMER_RC_TICKS * 8, POWERUP_TIMER_RC_TICKS * 9);
    regs(32'hFFFFFFFF);
    set_power_control_status;
    bus(1'b1, OFF_CONFIG, 32'h1F);
    ev(3, 100);
    hold;
    chk_in(n, 0, 0);
    bus(1'b1, OFF_CONFIG, 32'h2F);
    ev(4, BORC + 20);
    hold;
    chk_in(n, 0, 0);
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, OFF_CONFIG, 32'h38 | c);
      ev(2, 1);
      repeat (3) @(posedge hclk);
      exp_pc = pc + 13'h1;
      exp_to = 1; exp_pd = 0;
      regs(32'hFFFFFFFF);
      ev(c % 2, 1);
      exp_to = c % 2;
      hold;
      if (c < 3) begin
        chk_in(n, OST_CYCLES * 4, OST_CYCLES * 5);
      end else begin
        chk_in(n, CPU_START_CYCLES - 2, 1000);
      end
      chk_in(rr, 0, 0);
      chk(start_pc, exp_pc);
      regs(32'hFFFFFFFF);
    end
    ev(2, 1);
    repeat (3) @(posedge hclk);
    ev(3, 40);
    exp_to = 1; exp_pd = 0;
    hold;
    chk_in(rr, 1, 1);
    chk(start_pc, 13'h0);
    regs(32'hFFFFFFFF);
    ev(5, 1);
    exp_to = 1; exp_pd = 1; exp_power_control_status = 1;
    hold;
    chk_in(n, CPU_START_CYCLES - 2, 1000);
    regs(32'hFFFFFFFE);
    bus(1'b1, OFF_CONFIG, 32'h32);
    ev(5, 1);
    hold;
    chk_in(n, POWERUP_TIMER_RC_TICKS*8 + OST_CYCLES*4, POWERUP_TIMER_RC_TICKS*9 + OST_CYCLES*5);
    regs(32'hFFFFFFFE);
    stop_test;
  end
endmodule
`default_nettype wire
